/* File: tcc_channel.sv */
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
// How it works
// - Filter field resets to zero; zero means no filtering, sampled at base rate.
// - Filter is an event counter; output flips after N consecutive samples.
// - Codes 1 to 3 sample at kernel clock with N of 2, 4, 8.
// - Codes 4 to 9 sample at base/2, /4, /8 with N 6 then 8.
// - Codes 10 to 15 sample at base/16, /32 with N 5, 6, 8.
// - Edge divider captures on every 1st, 2nd, 4th or 8th event.
// - Edge divider count is cleared whenever the channel is disabled.
// - Direction 00 is output, 01 is input from timer input one.
// - Direction field writes are ignored while the channel is enabled.
// - Output mode polarity bit 0 is active high, 1 active low.
// - Input polarity pair selects rising, falling or both edges.
// - Disabled output is low with drive off; enabled with direction 00 drives polarised reference.
// - Input mode enable gates whether the counter is captured.
// - Capture register holds counter value from the latest qualified event.
module tcc_channel
	import tcc_pkg::*;
#(
	parameter int CNT_W = TCC_CW
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [TCC_AW-1:0] addr,
	input wire logic [TCC_DW-1:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [TCC_DW-1:0] rdata,
	input wire logic count_tick,
	input wire logic timer_input_one,
	output logic channel_output,
	output logic channel_output_en,
	output logic irq
);
	// The counter must fit in one bus word
	if (CNT_W < 1 || CNT_W > 32)
	begin : g_bad_width
		$error("CNT_W out of range");
	end

	logic [1:0] dir_ff;
	logic [1:0] div_sel_ff;
	logic [3:0] flt_sel_ff;
	logic ref_ff;
	logic en_ff;
	logic pol_ff;
	logic npol_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] cap_ff;
	logic [TCC_NSTAT-1:0] stat_ff;
	logic [TCC_NSTAT-1:0] mask_ff;
	logic [TCC_DW-1:0] rdata_ff;
	logic [TCC_DW-1:0] nxt_rdata;
	logic [2:0] pin_sync_ff;
	logic pin_level_ff;
	logic base_tick_ff;
	logic [TCC_SDIV_W-1:0] base_cnt_ff;
	logic filt;
	logic filt_d_ff;
	logic rise;
	logic fall;
	logic edge_evt;
	logic cap_pulse;
	logic is_input;
	logic is_output;

	function automatic logic hit(input logic [TCC_AW-1:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	assign is_input = (dir_ff == TCC_DIR_IN1);
	// Reserved directions neither drive the pin nor capture
	assign is_output = (dir_ff == TCC_DIR_OUT);

	// Mode register; direction only writable while the channel is off
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dir_ff <= TCC_RST_ZERO[1:0];
			div_sel_ff <= TCC_RST_ZERO[1:0];
			flt_sel_ff <= TCC_RST_ZERO[3:0];
			ref_ff <= 1'b0;
		end
		else if (wr_stb && hit(addr, TCC_OFS_MODE))
		begin
			if (!en_ff)
				dir_ff <= wdata[TCC_DIR_LSB +: 2];
			div_sel_ff <= wdata[TCC_DIV_LSB +: 2];
			flt_sel_ff <= wdata[TCC_FLT_LSB +: 4];
			ref_ff <= wdata[TCC_REF_BIT];
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			en_ff <= 1'b0;
			pol_ff <= 1'b0;
			npol_ff <= 1'b0;
		end
		else if (wr_stb && hit(addr, TCC_OFS_ENPOL))
		begin
			en_ff <= wdata[TCC_EN_BIT];
			pol_ff <= wdata[TCC_POL_BIT];
			npol_ff <= wdata[TCC_NPOL_BIT];
		end
	end

	// Free-running counter, software may overwrite it
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			cnt_ff <= '0;
		else if (wr_stb && hit(addr, TCC_OFS_CNT))
			cnt_ff <= wdata[CNT_W-1:0];
		else if (count_tick)
			cnt_ff <= cnt_ff + 1'b1;
	end

	// Pin synchroniser; a change counts once the last two stages agree
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_sync_ff <= 3'b000;
			pin_level_ff <= 1'b0;
		end
		else
		begin
			pin_sync_ff <= {pin_sync_ff[1:0], timer_input_one};
			if (pin_sync_ff[2] == pin_sync_ff[1])
				pin_level_ff <= pin_sync_ff[2];
		end
	end

	// Sampling base clock enable derived from the kernel clock
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			base_cnt_ff <= '0;
			base_tick_ff <= 1'b0;
		end
		else
		begin
			base_tick_ff <= (base_cnt_ff == TCC_SDIV_W'(TCC_BASE_DIV - 1));
			if (base_cnt_ff == TCC_SDIV_W'(TCC_BASE_DIV - 1))
				base_cnt_ff <= '0;
			else
				base_cnt_ff <= base_cnt_ff + 1'b1;
		end
	end

	tcc_filter u_filter (
		.clock(clock),
		.rst_n(rst_n),
		.base_tick(base_tick_ff),
		.input_filter_select(flt_sel_ff),
		.pin_level(pin_level_ff),
		.filt_level(filt)
	);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			filt_d_ff <= 1'b0;
		else
			filt_d_ff <= filt;
	end

	assign rise = filt & ~filt_d_ff;
	assign fall = ~filt & filt_d_ff;
	// Reserved pair 10 is treated as rising edge
	assign edge_evt = is_input && ((npol_ff & pol_ff) ? (rise | fall) : (pol_ff ? fall : rise));

	tcc_edge_div u_div (
		.clock(clock),
		.rst_n(rst_n),
		.clear(!en_ff),
		.edge_evt(edge_evt),
		.capture_edge_divider(div_sel_ff),
		.capture_pulse(cap_pulse)
	);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			cap_ff <= '0;
		else if (cap_pulse && en_ff)
			cap_ff <= cnt_ff;
	end

	// Sticky flags: set wins over a write-one clear in the same cycle
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			stat_ff <= '0;
		else
		begin
			for (int i = 0; i < TCC_NSTAT; i++)
			begin
				if (wr_stb && hit(addr, TCC_OFS_STAT) && wdata[i])
					stat_ff[i] <= 1'b0;
			end
			if (cap_pulse && en_ff)
			begin
				stat_ff[TCC_ST_CAP] <= 1'b1;
				if (stat_ff[TCC_ST_CAP])
					stat_ff[TCC_ST_OVR] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			mask_ff <= '0;
		else if (wr_stb && hit(addr, TCC_OFS_MASK))
			mask_ff <= wdata[TCC_NSTAT-1:0];
	end

	assign irq = |(stat_ff & mask_ff);

	// Output stage; complementary polarity assumed zero here
	assign channel_output = en_ff && is_output && (ref_ff ^ pol_ff);
	assign channel_output_en = en_ff && is_output;

	always_comb
	begin
		nxt_rdata = '0;
		if (hit(addr, TCC_OFS_MODE))
			nxt_rdata = TCC_DW'({ref_ff, flt_sel_ff, div_sel_ff, dir_ff});
		else if (hit(addr, TCC_OFS_ENPOL))
			nxt_rdata = TCC_DW'({npol_ff, 1'b0, pol_ff, en_ff});
		else if (hit(addr, TCC_OFS_CNT))
			nxt_rdata = TCC_DW'(cnt_ff);
		else if (hit(addr, TCC_OFS_CAPVAL))
			nxt_rdata = TCC_DW'(cap_ff);
		else if (hit(addr, TCC_OFS_STAT))
			nxt_rdata = TCC_DW'(stat_ff);
		else if (hit(addr, TCC_OFS_MASK))
			nxt_rdata = TCC_DW'(mask_ff);
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rdata_ff <= '0;
		else if (rd_stb)
			rdata_ff <= nxt_rdata;
		else
			rdata_ff <= '0;
	end

	assign rdata = rdata_ff;

	// Register bus and counter
	a_dir_locked: assert property (@(posedge clock) disable iff (!rst_n)
		en_ff && wr_stb && hit(addr, TCC_OFS_MODE) |=> $stable(dir_ff))
		else $error("direction changed while channel enabled");

	a_dir_open: assert property (@(posedge clock) disable iff (!rst_n)
		!en_ff && wr_stb && hit(addr, TCC_OFS_MODE) |=> dir_ff == $past(wdata[TCC_DIR_LSB +: 2]))
		else $error("direction not written while channel disabled");

	a_cnt_write: assert property (@(posedge clock) disable iff (!rst_n)
		wr_stb && hit(addr, TCC_OFS_CNT) |=> cnt_ff == $past(wdata[CNT_W-1:0]))
		else $error("counter write lost");

	a_cnt_hold: assert property (@(posedge clock) disable iff (!rst_n)
		!wr_stb && !count_tick |=> $stable(cnt_ff))
		else $error("counter moved without a tick");

	a_rdata_idle: assert property (@(posedge clock) disable iff (!rst_n)
		!rd_stb |=> rdata == '0)
		else $error("read data outside its cycle");

	// Capture path
	a_pin_agree: assert property (@(posedge clock) disable iff (!rst_n)
		(pin_level_ff != $past(pin_level_ff)) |-> ($past(pin_sync_ff[2]) == $past(pin_sync_ff[1])))
		else $error("pin level taken before the stages agreed");

	a_edge_rise: assert property (@(posedge clock) disable iff (!rst_n)
		is_input && !pol_ff && !npol_ff && edge_evt |-> filt && !filt_d_ff)
		else $error("rising edge select took another edge");

	a_edge_fall: assert property (@(posedge clock) disable iff (!rst_n)
		is_input && pol_ff && !npol_ff && edge_evt |-> !filt && filt_d_ff)
		else $error("falling edge select took another edge");

	a_edge_both: assert property (@(posedge clock) disable iff (!rst_n)
		is_input && pol_ff && npol_ff && (filt != filt_d_ff) |-> edge_evt)
		else $error("both edge select missed an edge");

	a_cap_needs_en: assert property (@(posedge clock) disable iff (!rst_n)
		!en_ff |-> !cap_pulse)
		else $error("capture pulse while disabled");

	a_cap_gated: assert property (@(posedge clock) disable iff (!rst_n)
		!en_ff |=> $stable(cap_ff))
		else $error("capture while disabled");

	a_cap_loads: assert property (@(posedge clock) disable iff (!rst_n)
		cap_pulse && en_ff |=> cap_ff == $past(cnt_ff) && stat_ff[TCC_ST_CAP])
		else $error("capture value or flag not updated");

	a_cap_hold: assert property (@(posedge clock) disable iff (!rst_n)
		!(cap_pulse && en_ff) |=> $stable(cap_ff))
		else $error("capture value changed without a capture");

	// Flags and outputs
	a_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n)
		stat_ff[TCC_ST_CAP] && !(wr_stb && hit(addr, TCC_OFS_STAT) && wdata[TCC_ST_CAP]) |=> stat_ff[TCC_ST_CAP])
		else $error("capture flag lost without a clear");

	a_ovr_sticky: assert property (@(posedge clock) disable iff (!rst_n)
		stat_ff[TCC_ST_OVR] && !(wr_stb && hit(addr, TCC_OFS_STAT) && wdata[TCC_ST_OVR]) |=> stat_ff[TCC_ST_OVR])
		else $error("overcapture flag lost without a clear");

	a_stat_clear: assert property (@(posedge clock) disable iff (!rst_n)
		wr_stb && hit(addr, TCC_OFS_STAT) && wdata[TCC_ST_CAP] && !(cap_pulse && en_ff) |=> !stat_ff[TCC_ST_CAP])
		else $error("capture flag not cleared");

	a_overcapture: assert property (@(posedge clock) disable iff (!rst_n)
		cap_pulse && en_ff && stat_ff[TCC_ST_CAP] |=> stat_ff[TCC_ST_OVR])
		else $error("overcapture not flagged");

	a_out_off: assert property (@(posedge clock) disable iff (!rst_n)
		!en_ff |-> !channel_output && !channel_output_en)
		else $error("output driven while disabled");

	a_out_polar: assert property (@(posedge clock) disable iff (!rst_n)
		channel_output_en |-> channel_output == (ref_ff ^ pol_ff))
		else $error("output polarity wrong");

	a_reserved_idle: assert property (@(posedge clock) disable iff (!rst_n)
		dir_ff[1] |-> !channel_output_en && !edge_evt)
		else $error("reserved direction drove or captured");
endmodule : tcc_channel

/* File: tcc_pkg.sv */
package tcc_pkg;
	localparam int TCC_AW = 8;
	localparam int TCC_DW = 32;
	localparam int TCC_CW = 16;
	// Register byte offsets
	localparam logic [7:0] TCC_OFS_MODE = 8'h18;
	localparam logic [7:0] TCC_OFS_ENPOL = 8'h20;
	localparam logic [7:0] TCC_OFS_CNT = 8'h24;
	localparam logic [7:0] TCC_OFS_CAPVAL = 8'h34;
	localparam logic [7:0] TCC_OFS_STAT = 8'h10;
	localparam logic [7:0] TCC_OFS_MASK = 8'h0C;
	// Mode register fields
	localparam int TCC_DIR_LSB = 0;
	localparam int TCC_DIV_LSB = 2;
	localparam int TCC_FLT_LSB = 4;
	localparam int TCC_REF_BIT = 8;
	// Enable/polarity register fields
	localparam int TCC_EN_BIT = 0;
	localparam int TCC_POL_BIT = 1;
	localparam int TCC_NPOL_BIT = 3;
	// Status bits
	localparam int TCC_ST_CAP = 0;
	localparam int TCC_ST_OVR = 1;
	localparam int TCC_NSTAT = 2;
	localparam logic [31:0] TCC_RST_ZERO = 32'h0000_0000;
	localparam logic [1:0] TCC_DIR_OUT = 2'b00;
	localparam logic [1:0] TCC_DIR_IN1 = 2'b01;
	// Sampling base clock: kernel clock divided by this ratio
	localparam int TCC_BASE_DIV = 1;
	localparam int TCC_SDIV_W = 5;
endpackage : tcc_pkg

/* File: tcc_filter.sv */
`timescale 1ns/100ps
module tcc_filter
	import tcc_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic base_tick,
	input wire logic [3:0] input_filter_select,
	input wire logic pin_level,
	output logic filt_level
);
	logic [TCC_SDIV_W-1:0] div_ff;
	logic [3:0] run_ff;
	logic filt_ff;
	logic samp_en;
	logic [3:0] need_n;

	// Sampling rate and count per code
	always_comb
	begin
		samp_en = base_tick;
		need_n = 4'd1;
		unique case (input_filter_select)
			4'h0: begin samp_en = base_tick; need_n = 4'd1; end
			4'h1: begin samp_en = 1'b1; need_n = 4'd2; end
			4'h2: begin samp_en = 1'b1; need_n = 4'd4; end
			4'h3: begin samp_en = 1'b1; need_n = 4'd8; end
			4'h4: begin samp_en = base_tick & (div_ff[0:0] == 1'b1); need_n = 4'd6; end
			4'h5: begin samp_en = base_tick & (div_ff[0:0] == 1'b1); need_n = 4'd8; end
			4'h6: begin samp_en = base_tick & (div_ff[1:0] == 2'b11); need_n = 4'd6; end
			4'h7: begin samp_en = base_tick & (div_ff[1:0] == 2'b11); need_n = 4'd8; end
			4'h8: begin samp_en = base_tick & (div_ff[2:0] == 3'b111); need_n = 4'd6; end
			4'h9: begin samp_en = base_tick & (div_ff[2:0] == 3'b111); need_n = 4'd8; end
			4'hA: begin samp_en = base_tick & (div_ff[3:0] == 4'hF); need_n = 4'd5; end
			4'hB: begin samp_en = base_tick & (div_ff[3:0] == 4'hF); need_n = 4'd6; end
			4'hC: begin samp_en = base_tick & (div_ff[3:0] == 4'hF); need_n = 4'd8; end
			4'hD: begin samp_en = base_tick & (div_ff == 5'h1F); need_n = 4'd5; end
			4'hE: begin samp_en = base_tick & (div_ff == 5'h1F); need_n = 4'd6; end
			4'hF: begin samp_en = base_tick & (div_ff == 5'h1F); need_n = 4'd8; end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			div_ff <= '0;
		else if (base_tick)
			div_ff <= div_ff + 5'd1;
	end

	// Event counter: output flips after N consecutive differing samples
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			run_ff <= 4'd0;
			filt_ff <= 1'b0;
		end
		else if (samp_en)
		begin
			if (pin_level == filt_ff)
				run_ff <= 4'd0;
			else if (run_ff + 4'd1 >= need_n)
			begin
				run_ff <= 4'd0;
				filt_ff <= pin_level;
			end
			else
				run_ff <= run_ff + 4'd1;
		end
	end

	assign filt_level = filt_ff;

	a_filter_hold: assert property (@(posedge clock) disable iff (!rst_n)
		(filt_ff != $past(filt_ff)) |-> $past(samp_en) && ($past(pin_level) == filt_ff))
		else $error("filter output changed without a matching sample");
	a_filter_bypass: assert property (@(posedge clock) disable iff (!rst_n)
		(input_filter_select == 4'h0 && samp_en && pin_level != filt_ff) |=> filt_ff == $past(pin_level))
		else $error("unfiltered code did not follow the sample");
endmodule : tcc_filter

/* File: tcc_edge_div.sv */
`timescale 1ns/100ps
module tcc_edge_div
	import tcc_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic edge_evt,
	input wire logic [1:0] capture_edge_divider,
	output logic capture_pulse
);
	logic [2:0] evt_ff;
	logic [2:0] last_cnt;

	always_comb
	begin
		unique case (capture_edge_divider)
			2'b00: last_cnt = 3'd0;
			2'b01: last_cnt = 3'd1;
			2'b10: last_cnt = 3'd3;
			2'b11: last_cnt = 3'd7;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			evt_ff <= 3'd0;
		else if (clear)
			evt_ff <= 3'd0;
		else if (edge_evt)
			evt_ff <= (evt_ff >= last_cnt) ? 3'd0 : evt_ff + 3'd1;
	end

	assign capture_pulse = !clear && edge_evt && (evt_ff >= last_cnt);

	a_divider_clear: assert property (@(posedge clock) disable iff (!rst_n)
		clear |=> evt_ff == 3'd0)
		else $error("edge divider count not cleared while disabled");
	a_divider_every: assert property (@(posedge clock) disable iff (!rst_n)
		capture_pulse |-> evt_ff == last_cnt)
		else $error("capture issued at wrong event count");
endmodule : tcc_edge_div

/* File: tcc_pin_model.sv */
`timescale 1ns/100ps
module tcc_pin_model
(
	input wire logic clock,
	output logic timer_input_one
);
	initial timer_input_one = 1'b0;

	// A level held until the next call, since a real source never floats this input
	task automatic drive(input logic lvl);
		@(posedge clock);
		timer_input_one <= lvl;
	endtask : drive
endmodule : tcc_pin_model

/* File: testbench.sv */
`timescale 1ns/100ps
module testbench;
	import tcc_pkg::*;
	logic clock;
	logic rst_n;
	logic [TCC_AW-1:0] addr;
	logic [TCC_DW-1:0] wdata;
	logic wr_stb;
	logic rd_stb;
	logic [TCC_DW-1:0] rdata;
	logic count_tick;
	logic pin;
	logic channel_output;
	logic channel_output_en;
	logic irq;
	int mismatches;
	int n_tests;
	logic [31:0] v;

	tcc_channel u_dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata), .count_tick(count_tick), .timer_input_one(pin),
		.channel_output(channel_output), .channel_output_en(channel_output_en), .irq(irq));
	tcc_pin_model u_pin (.clock(clock), .timer_input_one(pin));

	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1 d = rdata;
	endtask : rd

	// Reads the capture flag, then clears it so the next edge is judged alone
	task automatic ev(input logic exp);
		rd(TCC_OFS_STAT, v);
		chk("capture flag", v[TCC_ST_CAP], exp);
		wr(TCC_OFS_STAT, 32'h0000_0003);
	endtask : ev

	task automatic edge_at(input logic lvl, input logic exp);
		u_pin.drive(lvl);
		repeat (12) @(posedge clock);
		ev(exp);
	endtask : edge_at

	// Mode is written with the channel off, or the direction bits would be dropped
	task automatic cfg(input logic [3:0] flt, input logic [1:0] dv, input logic [1:0] pol);
		wr(TCC_OFS_ENPOL, 32'h0000_0000);
		wr(TCC_OFS_MODE, {24'h0000_00, flt, dv, TCC_DIR_IN1});
		wr(TCC_OFS_ENPOL, {28'h0000_000, pol[1], 1'b0, pol[0], 1'b1});
		wr(TCC_OFS_STAT, 32'h0000_0003);
	endtask : cfg

	task automatic t_regs;
		logic [7:0] ofs [7];
		ofs = '{TCC_OFS_MODE, TCC_OFS_ENPOL, TCC_OFS_CNT, TCC_OFS_CAPVAL, TCC_OFS_STAT, TCC_OFS_MASK, 8'h04};
		chk("outputs", {irq, channel_output, channel_output_en}, 32'h0000_0000);
		wr(8'h04, 32'hFFFF_FFFF);
		foreach (ofs[i])
		begin
			rd(ofs[i], v);
			chk("reset value", v, TCC_RST_ZERO);
		end
		wr(TCC_OFS_CNT, 32'hFFFF_1230);
		@(posedge clock);
		count_tick <= 1'b1;
		repeat (10) @(posedge clock);
		count_tick <= 1'b0;
		rd(TCC_OFS_CNT, v);
		chk("counter", v, 32'h0000_123A);
		wr(TCC_OFS_ENPOL, 32'h0000_0001);
		wr(TCC_OFS_MODE, {30'h0, TCC_DIR_IN1});
		rd(TCC_OFS_MODE, v);
		chk("direction locked", v[1:0], TCC_DIR_OUT);
		wr(TCC_OFS_ENPOL, 32'h0000_0000);
		wr(TCC_OFS_MODE, {30'h0, TCC_DIR_IN1});
		rd(TCC_OFS_MODE, v);
		chk("direction open", v[1:0], TCC_DIR_IN1);
		$display("test registers done");
	endtask : t_regs

	task automatic t_out;
		wr(TCC_OFS_MODE, 32'h0000_0100);
		#1 chk("off", {channel_output, channel_output_en}, 32'h0000_0000);
		wr(TCC_OFS_ENPOL, 32'h0000_0001);
		#1 chk("on high", {channel_output, channel_output_en}, 32'h0000_0003);
		wr(TCC_OFS_ENPOL, 32'h0000_0003);
		#1 chk("on low", {channel_output, channel_output_en}, 32'h0000_0001);
		wr(TCC_OFS_MODE, 32'h0000_0000);
		#1 chk("ref low", {channel_output, channel_output_en}, 32'h0000_0003);
		wr(TCC_OFS_ENPOL, 32'h0000_0000);
		wr(TCC_OFS_MODE, 32'h0000_0102);
		wr(TCC_OFS_ENPOL, 32'h0000_0001);
		#1 chk("reserved direction", {channel_output, channel_output_en}, 32'h0000_0000);
		wr(TCC_OFS_ENPOL, 32'h0000_0000);
		$display("test output done");
	endtask : t_out

	task automatic t_cap;
		wr(TCC_OFS_MASK, 32'h0000_0001);
		wr(TCC_OFS_CNT, 32'h0000_1234);
		cfg(4'h0, 2'b00, 2'b00);
		u_pin.drive(1'b1);
		repeat (12) @(posedge clock);
		chk("irq set", irq, 1'b1);
		rd(TCC_OFS_CAPVAL, v);
		chk("captured", v, 32'h0000_1234);
		wr(TCC_OFS_MASK, 32'h0000_0000);
		#1 chk("irq masked", irq, 1'b0);
		ev(1'b1);
		edge_at(1'b0, 1'b0);
		wr(TCC_OFS_CNT, 32'h0000_0055);
		edge_at(1'b1, 1'b1);
		rd(TCC_OFS_CAPVAL, v);
		chk("latest capture", v, 32'h0000_0055);
		edge_at(1'b0, 1'b0);
		wr(TCC_OFS_ENPOL, 32'h0000_0000);
		edge_at(1'b1, 1'b0);
		u_pin.drive(1'b0);
		cfg(4'h0, 2'b00, 2'b01);
		edge_at(1'b1, 1'b0);
		edge_at(1'b0, 1'b1);
		cfg(4'h0, 2'b00, 2'b11);
		edge_at(1'b1, 1'b1);
		edge_at(1'b0, 1'b1);
		u_pin.drive(1'b1);
		repeat (12) @(posedge clock);
		u_pin.drive(1'b0);
		repeat (12) @(posedge clock);
		rd(TCC_OFS_STAT, v);
		chk("overcapture", v, 32'h0000_0003);
		cfg(4'h0, 2'b00, 2'b10);
		edge_at(1'b1, 1'b1);
		edge_at(1'b0, 1'b0);
		$display("test capture done");
	endtask : t_cap

	task automatic t_div;
		for (int d = 0; d < 4; d++)
		begin
			cfg(4'h0, d[1:0], 2'b00);
			repeat ((1 << d) - 1)
			begin
				edge_at(1'b1, 1'b0);
				edge_at(1'b0, 1'b0);
			end
			edge_at(1'b1, 1'b1);
			edge_at(1'b0, 1'b0);
		end
		cfg(4'h0, 2'b01, 2'b00);
		edge_at(1'b1, 1'b0);
		edge_at(1'b0, 1'b0);
		wr(TCC_OFS_ENPOL, 32'h0000_0000);
		wr(TCC_OFS_ENPOL, 32'h0000_0001);
		edge_at(1'b1, 1'b0);
		edge_at(1'b0, 1'b0);
		edge_at(1'b1, 1'b1);
		edge_at(1'b0, 1'b0);
		$display("test divider done");
	endtask : t_div

	// Span is samples needed times sample spacing, with the base clock equal to the kernel clock
	task automatic t_filt;
		int n;
		int dv;
		int sp;
		for (int c = 1; c < 16; c++)
		begin
			n = (c < 4) ? (1 << c) : (c < 10) ? ((c % 2) ? 8 : 6) : ((c - 10) % 3 == 0) ? 5 : ((c - 10) % 3 == 1) ? 6 : 8;
			dv = (c < 4) ? 1 : (c < 10) ? (1 << ((c - 2) / 2)) : (c < 13) ? 16 : 32;
			sp = n * dv;
			cfg(c[3:0], 2'b00, 2'b00);
			u_pin.drive(1'b1);
			repeat (sp / 2 - 1) @(posedge clock);
			u_pin.drive(1'b0);
			repeat (sp + 20) @(posedge clock);
			ev(1'b0);
			u_pin.drive(1'b1);
			repeat (2 * sp + 20) @(posedge clock);
			ev(1'b1);
			edge_at(1'b0, 1'b0);
			repeat (2 * sp) @(posedge clock);
		end
		$display("test filter done");
	endtask : t_filt

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	initial
	begin
		addr = 8'h00;
		wdata = 32'h0000_0000;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		count_tick = 1'b0;
		rst_n = 1'b0;
		mismatches = 0;
		n_tests = 0;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		t_regs;
		t_out;
		t_cap;
		t_div;
		t_filt;
		summarize;
	end

	initial
	begin
		#(8 * 40000);
		mismatches++;
		summarize;
	end
endmodule : testbench
